//--- src/pin_sync2.sv
// Two-stage synchroniser for the reset pin level
`timescale 1ns/1ps
`default_nettype none
module pin_sync2
	import rst_wdog_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic srst_i,
	// Level
	input  wire logic d_i,
	output var  logic q_o
);

	typedef struct packed {
		logic s1;
		logic s2;
	} sync_state_t;

	sync_state_t q;
	sync_state_t d;

	// Pin idles high through its pullup
	always_comb
	begin
		d    = q;
		d.s1 = d_i;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			q <= 2'b11;
		else
			q <= d;
	end

	assign q_o = q.s2;

endmodule : pin_sync2
`default_nettype wire

//--- src/reset_sequencer_watchdog.sv
// Reset gathering, reset pin sequencing and watchdog with APB registers
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer_watchdog
	import rst_wdog_pkg::*;
#(
	parameter bit          HAS_ILLEGAL_ADDR = 1'b1,
	parameter int unsigned WDOG_SHORT       = 2 ** WDOG_SHORT_LOG2,
	parameter int unsigned WDOG_LONG        = 2 ** WDOG_LONG_LOG2
)
(
	// Clock and reset
	input  wire logic     clk_sys_i,
	input  wire logic     srst_i,
	// APB slave
	input  wire apb_req_t apb_req_i,
	output var  apb_rsp_t apb_rsp_o,
	// Reset sources from the core
	input  wire rst_src_t src_i,
	input  wire logic     bdm_active_i,
	// Reset pin, open drain
	input  wire logic     rst_pin_i,
	output var  logic     rst_pin_o,
	output var  logic     rst_pin_oe_n_o,
	// System side
	output var  logic     sys_rst_o,
	output var  logic     irq_o
);

	typedef struct packed {
		seq_state_t  state;
		logic [5:0]  cnt;
		logic        div;
		logic [7:0]  cause;
		logic        opt_en;
		logic        opt_sel;
		logic        opt_lock;
		logic [2:0]  evt;
		logic [2:0]  mask;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        sys_rst;
		logic        oe_n;
		logic        irq;
	} core_state_t;

	// Power-up begins as a full sequence with the power-on flag
	localparam core_state_t Q_RESET = '{
		state:    ST_DRIVE,
		cnt:      6'h00,
		div:      1'b0,
		cause:    CAUSE_RESET,
		opt_en:   OPT_EN_RESET,
		opt_sel:  OPT_SEL_RESET,
		opt_lock: 1'b0,
		evt:      3'h0,
		mask:     EVT_MASK_RESET,
		prdata:   32'h00000000,
		pready:   1'b0,
		pslverr:  1'b0,
		sys_rst:  1'b1,
		oe_n:     1'b0,
		irq:      1'b0
	};

	core_state_t q;
	core_state_t d;

	logic        pin_sync;
	logic        pin_low;
	logic        tick;
	logic        wdog_to;
	logic        wdog_run;
	logic        wdog_clear;
	logic        setup;
	logic        access;
	logic        wr;
	logic        service;
	logic        wr_opt;
	logic        enter;
	logic [7:0]  new_cause;
	logic [2:0]  ev;
	logic [2:0]  w1c;
	logic [31:0] rd;
	logic        mapped;

	pin_sync2 u_pin_sync (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.d_i       (rst_pin_i),
		.q_o       (pin_sync)
	);

	assign pin_low = ~pin_sync;

	// Bus rate is half the core clock
	assign tick = q.div;

	// Counter is held clear during the sequence so each reset restarts it
	assign wdog_run   = q.opt_en && !bdm_active_i && (q.state == ST_RUN);
	assign wdog_clear = service || (q.state != ST_RUN);

	wdog_counter #(
		.SHORT_CYCLES (WDOG_SHORT),
		.LONG_CYCLES  (WDOG_LONG)
	) u_wdog (
		.clk_sys_i  (clk_sys_i),
		.srst_i     (srst_i),
		.tick_i     (tick),
		.run_i      (wdog_run),
		.clear_i    (wdog_clear),
		.long_sel_i (q.opt_sel),
		.timeout_o  (wdog_to)
	);

	// Bus decode; pready comes one cycle after setup, so no wait states
	assign setup   = apb_req_i.psel && !apb_req_i.penable;
	assign access  = apb_req_i.psel && apb_req_i.penable && q.pready;
	assign wr      = access && apb_req_i.pwrite;
	assign service = wr && (apb_req_i.paddr == OFS_RESET_STATUS);
	assign wr_opt  = wr && (apb_req_i.paddr == OFS_SYS_OPTIONS);

	assign new_cause = cause_of(src_i, wdog_to, HAS_ILLEGAL_ADDR);

	// Pin low only counts as a new entry while running; during the
	// sequence it is our own drive or the held-low case below
	assign enter = (|new_cause) || src_i.bdm_force
		|| ((q.state == ST_RUN) && pin_low);

	always_comb
	begin
		rd     = 32'h00000000;
		mapped = 1'b1;
		unique case (apb_req_i.paddr)
			OFS_RESET_STATUS: rd[7:0] = q.cause;
			OFS_SYS_OPTIONS:
			begin
				rd[OPT_EN_BIT]   = q.opt_en;
				rd[OPT_SEL_BIT]  = q.opt_sel;
				rd[OPT_LOCK_BIT] = q.opt_lock;
			end
			OFS_EVT_STATUS:   rd[2:0] = q.evt;
			OFS_EVT_MASK:     rd[2:0] = q.mask;
			default:          mapped = 1'b0;
		endcase
	end

	always_comb
	begin
		d     = q;
		ev    = 3'h0;
		w1c   = 3'h0;
		d.div = ~q.div;

		unique case (q.state)
			ST_DRIVE:
			begin
				if (tick)
				begin
					if (q.cnt == DRIVE_LAST)
					begin
						d.state = ST_SETTLE;
						d.cnt   = 6'h00;
					end
					else
						d.cnt = q.cnt + 6'h01;
				end
			end
			ST_SETTLE:
			begin
				if (tick)
				begin
					if (q.cnt == SETTLE_LAST)
					begin
						d.cnt = 6'h00;
						// Held low from outside: flag it and keep the chip in reset
						if (pin_low)
						begin
							d.cause[CAUSE_PIN] = 1'b1;
							ev[EVT_PIN_HELD]   = 1'b1;
						end
						else
						begin
							d.state          = ST_RUN;
							ev[EVT_SEQ_DONE] = 1'b1;
						end
					end
					else
						d.cnt = q.cnt + 6'h01;
				end
			end
			ST_RUN:
			begin
				d.cnt = 6'h00;
			end
		endcase

		// Options take only the first write; later ones are dropped
		if (wr_opt)
		begin
			if (!q.opt_lock)
			begin
				d.opt_en   = apb_req_i.pwdata[OPT_EN_BIT];
				d.opt_sel  = apb_req_i.pwdata[OPT_SEL_BIT];
				d.opt_lock = 1'b1;
			end
			else
				ev[EVT_OPT_REJECT] = 1'b1;
		end

		if (wr && (apb_req_i.paddr == OFS_EVT_STATUS))
			w1c = apb_req_i.pwdata[2:0];
		if (wr && (apb_req_i.paddr == OFS_EVT_MASK))
			d.mask = apb_req_i.pwdata[2:0];

		// Any entry restarts the whole sequence and unlocks the options
		if (enter)
		begin
			d.state    = ST_DRIVE;
			d.cnt      = 6'h00;
			// Restart the divider so the drive spans whole bus cycles
			d.div      = 1'b0;
			d.cause    = new_cause;
			d.opt_en   = OPT_EN_RESET;
			d.opt_sel  = OPT_SEL_RESET;
			d.opt_lock = 1'b0;
		end

		// Set beats clear when both land together
		d.evt = (q.evt & ~w1c) | ev;

		d.pready  = setup;
		d.pslverr = setup && !mapped;
		d.prdata  = (setup && !apb_req_i.pwrite) ? rd : 32'h00000000;

		d.sys_rst = (d.state != ST_RUN);
		d.oe_n    = (d.state != ST_DRIVE);
		d.irq     = |(d.evt & d.mask);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			q <= Q_RESET;
		else
			q <= d;
	end

	// Pin data is constant low; only the enable toggles
	assign rst_pin_o         = 1'b0;
	assign rst_pin_oe_n_o    = q.oe_n;
	assign sys_rst_o         = q.sys_rst;
	assign irq_o             = q.irq;
	assign apb_rsp_o.prdata  = q.prdata;
	assign apb_rsp_o.pready  = q.pready;
	assign apb_rsp_o.pslverr = q.pslverr;

	// Checking aids: bus ticks seen in one uninterrupted drive
	logic [6:0] drv_seen;

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			drv_seen <= 7'h00;
		else if (enter)
			drv_seen <= 7'h00;
		else if (tick && (q.state == ST_DRIVE))
			drv_seen <= drv_seen + 7'h01;
	end

	// Bus ticks since the pin was let go or last found held low
	logic [6:0] settle_seen;

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			settle_seen <= 7'h00;
		else if (enter || (q.state != ST_SETTLE) || ev[EVT_PIN_HELD])
			settle_seen <= 7'h00;
		else if (tick)
			settle_seen <= settle_seen + 7'h01;
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	drive_len_a: assert property ($rose(rst_pin_oe_n_o) |-> drv_seen == 7'(DRIVE_TICKS))
		else $error("reset pin drive was not 34 bus cycles");
	tick_half_a: assert property (tick |=> !tick ##1 (tick || $past(enter)))
		else $error("bus enable is not half rate");
	pin_release_a: assert property ((q.state != ST_DRIVE) |-> rst_pin_oe_n_o)
		else $error("reset pin driven outside drive period");
	pin_sample_a: assert property ((q.state == ST_SETTLE && q.cnt == SETTLE_LAST
		&& tick && pin_low && !enter) |=> q.cause[CAUSE_PIN] && sys_rst_o)
		else $error("held-low pin not recorded as cause");
	src_record_a: assert property ((q.state == ST_RUN && src_i.low_volt)
		|=> sys_rst_o && q.cause[CAUSE_LOWV] && !rst_pin_oe_n_o)
		else $error("low voltage reset not taken");
	debug_noflag_a: assert property ((src_i.bdm_force && !(|new_cause))
		|=> q.cause == 8'h00 && q.state == ST_DRIVE)
		else $error("debug reset left a cause flag");
	wdog_reset_a: assert property (wdog_to |=> q.cause[CAUSE_WDOG] && sys_rst_o)
		else $error("watchdog timeout did not reset");
	wdog_gate_a: assert property ((!q.opt_en && $past(q.opt_en) == 1'b0) |-> !wdog_to)
		else $error("disabled watchdog fired");
	service_keep_a: assert property ((service && !enter) |=> q.cause == $past(q.cause))
		else $error("service write altered reset status");
	reset_default_a: assert property (enter |=> q.opt_en && !q.opt_lock)
		else $error("reset left watchdog disabled");
	write_once_a: assert property ((wr_opt && q.opt_lock && !enter)
		|=> q.opt_en == $past(q.opt_en) && q.opt_sel == $past(q.opt_sel))
		else $error("locked options changed");
	debug_freeze_a: assert property (bdm_active_i |=> !wdog_to)
		else $error("watchdog fired in background debug");
	bus_phase_a: assert property (enter |=> !tick)
		else $error("bus divider not restarted on reset entry");
	settle_len_a: assert property ($fell(sys_rst_o) |-> settle_seen == 7'(SETTLE_TICKS))
		else $error("reset pin not sampled 38 bus cycles after release");
	run_release_a: assert property ((q.state == ST_SETTLE && q.cnt == SETTLE_LAST && tick
		&& !pin_low && !enter) |=> !sys_rst_o && q.state == ST_RUN)
		else $error("released pin did not end the reset");
	opt_lock_a: assert property ((wr_opt && !q.opt_lock && !enter)
		|=> q.opt_lock && q.opt_en == $past(apb_req_i.pwdata[OPT_EN_BIT]))
		else $error("first options write not taken");
	cause_hold_a: assert property ((q.state == ST_RUN && !enter) |=> $stable(q.cause))
		else $error("reset status changed without a reset");

	// Bus answer and event register
	ready_once_a: assert property (apb_rsp_o.pready |-> $past(setup))
		else $error("bus answer without a setup cycle");
	unmapped_err_a: assert property ((setup && !mapped)
		|=> apb_rsp_o.pslverr && (apb_rsp_o.prdata == 32'h00000000))
		else $error("unmapped access not refused");
	evt_wins_a: assert property ((|ev) |=> ((q.evt & $past(ev)) == $past(ev)))
		else $error("event flag lost to a clear");

	seq_done_c: cover property (ev[EVT_SEQ_DONE]);
	pin_held_c: cover property (ev[EVT_PIN_HELD]);
	wdog_fire_c: cover property (wdog_to);
	opt_reject_c: cover property (ev[EVT_OPT_REJECT]);
	irq_rise_c: cover property ($rose(irq_o));

endmodule : reset_sequencer_watchdog
`default_nettype wire

//--- src/rst_wdog_pkg.sv
// Constants, types and helpers shared by the reset sequencer and watchdog
// Notes on behaviour
// - Every entry into reset drives the reset pin low for exactly 34 bus cycles.
// - Bus cycles that time the pin drive and the watchdog run at half the core clock rate.
// - After the drive period the pin is let go so the pullup can raise it.
// - Once released the pin is sampled 38 bus cycles later and flagged as cause if still low.
// - Power-on, low voltage, watchdog, illegal opcode, illegal address, debug and pin resets are taken.
// - The reset status register keeps one cause flag per source except the debug forced reset.
// - An enabled watchdog that is not serviced in time forces a full system reset.
// - The watchdog only runs while its enable bit in the system options register is set.
// - Any write to the reset status address restarts the watchdog and leaves the flags alone.
// - Every reset leaves the watchdog enabled.
// - The system options register takes only the first write after reset.
// - The period select picks a timeout of 2^18 or 2^20 bus cycles.
// - The watchdog is frozen while the processor sits in active background debug mode.
package rst_wdog_pkg;

	localparam int unsigned DRIVE_TICKS     = 34;
	localparam int unsigned SETTLE_TICKS    = 38;
	localparam int unsigned WDOG_SHORT_LOG2 = 18;
	localparam int unsigned WDOG_LONG_LOG2  = 20;
	localparam int unsigned WDOG_W          = 21;

	localparam logic [5:0] DRIVE_LAST  = 6'(DRIVE_TICKS - 1);
	localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_TICKS - 1);

	// Register byte offsets
	localparam logic [11:0] OFS_RESET_STATUS = 12'h000;
	localparam logic [11:0] OFS_SYS_OPTIONS  = 12'h004;
	localparam logic [11:0] OFS_EVT_STATUS   = 12'h008;
	localparam logic [11:0] OFS_EVT_MASK     = 12'h00C;

	// Reset cause flag positions
	localparam int CAUSE_LOWV    = 1;
	localparam int CAUSE_ILLADDR = 3;
	localparam int CAUSE_ILLOP   = 4;
	localparam int CAUSE_WDOG    = 5;
	localparam int CAUSE_PIN     = 6;
	localparam int CAUSE_POR     = 7;

	// System options fields
	localparam int OPT_EN_BIT   = 0;
	localparam int OPT_SEL_BIT  = 1;
	localparam int OPT_LOCK_BIT = 2;

	// Event flags
	localparam int EVT_SEQ_DONE   = 0;
	localparam int EVT_PIN_HELD   = 1;
	localparam int EVT_OPT_REJECT = 2;

	// Reset values
	localparam logic [7:0] CAUSE_RESET    = 8'h80;
	localparam logic       OPT_EN_RESET   = 1'b1;
	localparam logic       OPT_SEL_RESET  = 1'b1;
	localparam logic [2:0] EVT_MASK_RESET = 3'h0;

	typedef enum logic [2:0] {
		ST_DRIVE  = 3'b001,
		ST_SETTLE = 3'b010,
		ST_RUN    = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic por;
		logic low_volt;
		logic illop;
		logic illaddr;
		logic bdm_force;
	} rst_src_t;

	// Debug forced reset resets the chip but leaves no flag
	function automatic logic [7:0] cause_of(rst_src_t s, logic wdog, logic has_ia);
		logic [7:0] c;
		c = 8'h00;
		c[CAUSE_POR]     = s.por;
		c[CAUSE_LOWV]    = s.low_volt;
		c[CAUSE_ILLOP]   = s.illop;
		c[CAUSE_ILLADDR] = s.illaddr & has_ia;
		c[CAUSE_WDOG]    = wdog;
		return c;
	endfunction : cause_of

endpackage : rst_wdog_pkg

//--- src/wdog_counter.sv
// Watchdog period counter on the bus-rate enable
`timescale 1ns/1ps
`default_nettype none
module wdog_counter
	import rst_wdog_pkg::*;
#(
	parameter int unsigned SHORT_CYCLES = 2 ** WDOG_SHORT_LOG2,
	parameter int unsigned LONG_CYCLES  = 2 ** WDOG_LONG_LOG2
)
(
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic srst_i,
	// Control
	input  wire logic tick_i,
	input  wire logic run_i,
	input  wire logic clear_i,
	input  wire logic long_sel_i,
	// Result
	output var  logic timeout_o
);

	localparam logic [WDOG_W-1:0] SHORT_LAST = WDOG_W'(SHORT_CYCLES - 1);
	localparam logic [WDOG_W-1:0] LONG_LAST  = WDOG_W'(LONG_CYCLES - 1);

	typedef struct packed {
		logic [WDOG_W-1:0] cnt;
		logic              timeout;
	} wdog_state_t;

	wdog_state_t       q;
	wdog_state_t       d;
	logic [WDOG_W-1:0] last;

	always_comb
	begin
		d         = q;
		d.timeout = 1'b0;
		last      = long_sel_i ? LONG_LAST : SHORT_LAST;
		if (clear_i)
			d.cnt = '0;
		else if (run_i && tick_i)
		begin
			if (q.cnt >= last)
			begin
				d.cnt     = '0;
				d.timeout = 1'b1;
			end
			else
				d.cnt = q.cnt + 21'h000001;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			q <= '0;
		else
			q <= d;
	end

	assign timeout_o = q.timeout;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	clear_zero_a: assert property (clear_i |=> q.cnt == '0)
		else $error("watchdog count not restarted by clear");
	period_hit_a: assert property (timeout_o |-> $past(q.cnt) == $past(last))
		else $error("watchdog fired away from selected period");
	freeze_hold_a: assert property ((!run_i && !clear_i) |=> $stable(q.cnt))
		else $error("watchdog moved while halted");
	count_tick_a: assert property ((run_i && !tick_i && !clear_i) |=> $stable(q.cnt))
		else $error("watchdog counted off the bus-rate enable");

endmodule : wdog_counter
`default_nettype wire

//--- tb/reset_sequencer_watchdog_tb.sv
// Self-checking bench for the reset sequencer and watchdog
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer_watchdog_tb
	import rst_wdog_pkg::*;
;
	logic        clk_sys_i = 1'b0;
	logic        srst_i    = 1'b1;
	apb_req_t    req       = '0;
	apb_rsp_t    rsp;
	rst_src_t    src       = '0;
	logic        bdm       = 1'b0;
	logic        hold      = 1'b0;
	logic        pin;
	logic        pin_d;
	logic        oe_n;
	logic        sys_rst;
	logic        irq;
	int          fails       = 0;
	int          check_count = 0;
	int          d;
	int          s;
	int          n;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  exp_cause [5] = '{8'h00, 8'h08, 8'h10, 8'h02, 8'h80};

	always #10 clk_sys_i = ~clk_sys_i;

	// Short watchdog periods keep the run brief
	reset_sequencer_watchdog #(.HAS_ILLEGAL_ADDR(1'b1), .WDOG_SHORT(16), .WDOG_LONG(64))
	reset_sequencer_watchdog_inst
	(
		.clk_sys_i      (clk_sys_i),
		.srst_i         (srst_i),
		.apb_req_i      (req),
		.apb_rsp_o      (rsp),
		.src_i          (src),
		.bdm_active_i   (bdm),
		.rst_pin_i      (pin),
		.rst_pin_o      (pin_d),
		.rst_pin_oe_n_o (oe_n),
		.sys_rst_o      (sys_rst),
		.irq_o          (irq)
	);

	rst_pin_model rst_pin_model_inst
	(
		.pin_d_i    (pin_d),
		.pin_oe_n_i (oe_n),
		.hold_low_i (hold),
		.pin_o      (pin)
	);

	task automatic end_sim();
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
		@(posedge clk_sys_i);
		req.penable <= 1'b1;
		do
		begin
			@(posedge clk_sys_i);
			k++;
		end
		while (rsp.pready !== 1'b1 && k < 20);
		if (rsp.pready !== 1'b1)
			fails++;
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask : apb

	task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp, input string name);
		apb(1'b0, addr, 32'h0);
		check(name, rd, exp);
	endtask : rdchk

	// Measures drive and settle spans of one reset sequence
	task automatic wait_seq();
		d = 0;
		s = 0;
		n = 0;
		while (oe_n !== 1'b0 && n < 3000)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (oe_n === 1'b0 && d < 300)
		begin
			@(posedge clk_sys_i);
			d++;
		end
		check("pin_released", pin, 1'b1);
		while (sys_rst === 1'b1 && s < 300)
		begin
			@(posedge clk_sys_i);
			s++;
		end
		if (n >= 3000 || d >= 300 || s >= 300)
			fails++;
	endtask : wait_seq

	task automatic cnt_rst();
		n = 0;
		while (sys_rst !== 1'b1 && n < 3000)
		begin
			@(posedge clk_sys_i);
			n++;
		end
	endtask : cnt_rst

	initial
	begin
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		rdchk(OFS_RESET_STATUS, 32'h80, "cause_por");
		rdchk(OFS_SYS_OPTIONS, 32'h3, "opt_default");
		wait_seq();
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk_sys_i);
			src <= rst_src_t'(5'(1 << i));
			@(posedge clk_sys_i);
			src <= '0;
			wait_seq();
			check("drive_len", 32'(d), 32'(2 * DRIVE_TICKS));
			check("settle_len", 32'(s >= 76 && s <= 80), 32'h1);
			rdchk(OFS_RESET_STATUS, 32'(exp_cause[i]), "cause_src");
		end
		// Outside party keeps the pin low past the first sample
		hold <= 1'b1;
		repeat (200) @(posedge clk_sys_i);
		hold <= 1'b0;
		n = 0;
		while (sys_rst !== 1'b0 && n < 1000)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		if (n >= 1000)
			fails++;
		rdchk(OFS_RESET_STATUS, 32'h40, "cause_pin");
		// Service from the main flow only, never from an interrupt handler
		apb(1'b1, OFS_RESET_STATUS, 32'hFF);
		apb(1'b1, OFS_SYS_OPTIONS, 32'h1);
		apb(1'b1, OFS_RESET_STATUS, 32'h00);
		rdchk(OFS_SYS_OPTIONS, 32'h5, "opt_locked");
		apb(1'b1, OFS_SYS_OPTIONS, 32'h2);
		apb(1'b1, OFS_RESET_STATUS, 32'h5A);
		rdchk(OFS_SYS_OPTIONS, 32'h5, "opt_second");
		repeat (10)
		begin
			repeat (20) @(posedge clk_sys_i);
			apb(1'b1, OFS_RESET_STATUS, 32'hFF);
		end
		check("serviced", sys_rst, 1'b0);
		rdchk(OFS_RESET_STATUS, 32'h40, "cause_kept");
		apb(1'b1, OFS_RESET_STATUS, 32'h00);
		cnt_rst();
		check("short_period", 32'(n >= 30 && n <= 36), 32'h1);
		wait_seq();
		cnt_rst();
		check("long_period", 32'(n >= 124 && n <= 134), 32'h1);
		wait_seq();
		rdchk(OFS_RESET_STATUS, 32'h20, "cause_wdog");
		rdchk(OFS_SYS_OPTIONS, 32'h3, "opt_after_wdog");
		bdm <= 1'b1;
		repeat (300) @(posedge clk_sys_i);
		check("bdm_frozen", sys_rst, 1'b0);
		bdm <= 1'b0;
		cnt_rst();
		check("bdm_resumed", sys_rst, 1'b1);
		wait_seq();
		apb(1'b1, OFS_EVT_STATUS, 32'h7);
		rdchk(OFS_EVT_STATUS, 32'h0, "evt_clear");
		apb(1'b1, OFS_EVT_MASK, 32'h4);
		rdchk(OFS_EVT_MASK, 32'h4, "mask_rw");
		apb(1'b1, OFS_SYS_OPTIONS, 32'h0);
		apb(1'b1, OFS_SYS_OPTIONS, 32'h3);
		rdchk(OFS_SYS_OPTIONS, 32'h4, "opt_disabled");
		check("irq_set", irq, 1'b1);
		apb(1'b1, OFS_EVT_MASK, 32'h0);
		repeat (2) @(posedge clk_sys_i);
		check("irq_masked", irq, 1'b0);
		apb(1'b1, OFS_EVT_MASK, 32'h4);
		repeat (2) @(posedge clk_sys_i);
		check("irq_unmasked", irq, 1'b1);
		apb(1'b1, OFS_EVT_STATUS, 32'h4);
		repeat (2) @(posedge clk_sys_i);
		check("irq_cleared", irq, 1'b0);
		repeat (300) @(posedge clk_sys_i);
		check("wdog_off", sys_rst, 1'b0);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped_err", err, 1'b1);
		check("unmapped_data", rd, 32'h0);
		end_sim();
	end

	// Hang guard, well beyond the expected run
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		fails++;
		end_sim();
	end
endmodule : reset_sequencer_watchdog_tb
`default_nettype wire

//--- tb/rst_pin_model.sv
// Reset pin model: open-drain device driver, pullup and an outside party
`timescale 1ns/1ps
`default_nettype none
module rst_pin_model
(
	// Device side
	input  wire logic pin_d_i,
	input  wire logic pin_oe_n_i,
	// Outside party
	input  wire logic hold_low_i,
	// Wire level
	output var  logic pin_o
);
	// Pullup wins unless someone pulls the line low
	always_comb
	begin
		pin_o = 1'b1;
		if ((!pin_oe_n_i && !pin_d_i) || hold_low_i)
		begin
			pin_o = 1'b0;
		end
	end
endmodule : rst_pin_model
`default_nettype wire
